//--- icr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// host side: one register word per strobe
// ----------------------------------------------------------------
module icr_host_model (
  // clock
  input wire logic clk_in,
  // register write port
  output logic reg_wr_out,
  output logic [15:0] reg_wdata_out
);
  // idle at time zero
  initial begin
    reg_wr_out = 1'b0;
    reg_wdata_out = 16'h0000;
  end
  // word held for exactly one taking edge
  task automatic send(input logic [15:0] word);
    @(posedge clk_in);
    #1;
    reg_wr_out = 1'b1;
    reg_wdata_out = word;
    @(posedge clk_in);
    #1;
    reg_wr_out = 1'b0;
    reg_wdata_out = ~word; // stale word must never look valid
  endtask
endmodule
`default_nettype wire

//--- icr_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// port checker
// ----------------------------------------------------------------
module icr_monitor (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // watched ports
  input wire logic [15:0] reg_rdata_out,
  input wire logic [1:0] operating_mode_field_in,
  input wire logic main_regulator_warn_in,
  input wire logic main_supply_low_irq_out,
  input wire logic xcvr_supply_low_irq_out,
  input wire logic lin_wake_irq_out,
  input wire icr_pkg::icr_lin_state_t lin_state_out,
  input wire logic lin_wake_det_en_out,
  input wire logic lin_receive_pin_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  // warning low, then high through both sync stages
  sequence s_main_rise;
    !main_regulator_warn_in ##1 main_regulator_warn_in [*3];
  endsequence
  a_addr_field: assert property (reg_rdata_out[15:13] == 3'h2 &&
    reg_rdata_out[8:0] == 9'h000) else $error("address field wrong");
  a_lock_holds: assert property (reg_rdata_out[12] |=>
    $stable(reg_rdata_out)) else $error("locked register changed");
  a_main_gate: assert property (main_supply_low_irq_out |->
    reg_rdata_out[11]) else $error("main irq while disabled");
  a_main_timing: assert property (s_main_rise ##0 reg_rdata_out[11]
    |=> main_supply_low_irq_out) else $error("main irq missing");
  a_xcvr_gate: assert property (xcvr_supply_low_irq_out |->
    reg_rdata_out[10] ##1 !xcvr_supply_low_irq_out)
    else $error("xcvr irq wrong");
  a_lin_active: assert property (!$past(reset_in) &&
    !reg_rdata_out[9] && $past(operating_mode_field_in[1]) |->
    lin_state_out == icr_pkg::ICR_LIN_ACTIVE) else $error("lin not active");
  a_lin_off: assert property (!$past(reset_in) && !reg_rdata_out[9] &&
    !$past(operating_mode_field_in[1]) |-> !lin_wake_det_en_out &&
    lin_state_out == icr_pkg::ICR_LIN_OFF) else $error("lin not off");
  a_lin_lowpower: assert property (reg_rdata_out[9] |->
    lin_wake_det_en_out && lin_state_out == icr_pkg::ICR_LIN_LOWPOWER)
    else $error("lin not low power");
  a_flag_clear: assert property (lin_state_out ==
    icr_pkg::ICR_LIN_ACTIVE |=> lin_receive_pin_out)
    else $error("wake flag kept");
  a_wake_gate: assert property (lin_wake_irq_out |->
    $past(lin_state_out) == icr_pkg::ICR_LIN_LOWPOWER &&
    !lin_receive_pin_out) else $error("wake irq wrong");
endmodule
bind icr_top icr_monitor icr_monitor_inst (.clk_in(clk_in),
  .reset_in(reset_in), .reg_rdata_out(reg_rdata_out),
  .operating_mode_field_in(operating_mode_field_in),
  .main_regulator_warn_in(main_regulator_warn_in),
  .main_supply_low_irq_out(main_supply_low_irq_out),
  .xcvr_supply_low_irq_out(xcvr_supply_low_irq_out),
  .lin_wake_irq_out(lin_wake_irq_out), .lin_state_out(lin_state_out),
  .lin_wake_det_en_out(lin_wake_det_en_out),
  .lin_receive_pin_out(lin_receive_pin_out));
`default_nettype wire

//--- icr_pkg.sv
package icr_pkg;

  // ----------------------------------------------------------------
  // register layout
  // ----------------------------------------------------------------
  localparam logic [2:0] ICR_SELECT = 3'h2;     // fixed register address
  localparam int ICR_SEL_HI = 15;
  localparam int ICR_SEL_LO = 13;
  localparam int ICR_LOCK_BIT = 12;
  localparam int ICR_MAIN_EN_BIT = 11;
  localparam int ICR_XCVR_EN_BIT = 10;
  localparam int ICR_STB_BIT = 9;
  localparam logic [8:0] ICR_LOW_ZERO = 9'h000; // bits outside this block

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic ICR_LOCK_RST = 1'h0;
  localparam logic ICR_MAIN_EN_RST = 1'h0;
  localparam logic ICR_XCVR_EN_RST = 1'h0;
  localparam logic ICR_STB_RST = 1'h0;

  // ----------------------------------------------------------------
  // operating mode codes
  // ----------------------------------------------------------------
  localparam logic [1:0] ICR_MODE_STANDBY = 2'h0;
  localparam logic [1:0] ICR_MODE_SLEEP = 2'h1;
  localparam logic [1:0] ICR_MODE_NORM_XOFF = 2'h2;
  localparam logic [1:0] ICR_MODE_NORM_XON = 2'h3;
  localparam int ICR_MODE_NORMAL_BIT = 1;       // mode 1x is normal

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ICR_LIN_OFF,
    ICR_LIN_ACTIVE,
    ICR_LIN_LOWPOWER
  } icr_lin_state_t;

  typedef struct packed {
    logic write_lock;
    logic main_supply_low_irq_en;
    logic xcvr_supply_low_irq_en;
    logic lin_standby_ctrl;
  } icr_ctrl_t;

  typedef struct packed {
    logic main_warn;
    logic xcvr_warn;
    logic lin_wake;
  } icr_events_t;

endpackage

//--- icr_sync.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------------
// two-stage synchroniser for asynchronous pin levels
// ------------------------------------------------------------------
module icr_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  // first stage is read only by the second stage
  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;

endmodule

`default_nettype wire

//--- icr_top.sv
// Behaviour
// - address bits 15:13 always read 010
// - lock bit resets 0; 1 blocks writes
// - bit 11 gates main supply warning request
// - bit 10 gates transceiver supply warning request
// - bit9 0 in normal mode: LIN active
// - same condition clears LIN wake flag
// - mode codes: standby, sleep, normal off/on
// - bit9 0, standby/sleep: LIN off, no wake
// - bit9 1: low power, wake detect enabled
`timescale 1ns/1ps
`default_nettype none

module icr_top (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // register access from the serial interface frame logic
  input wire logic reg_wr_in,
  input wire logic [15:0] reg_wdata_in,
  output logic [15:0] reg_rdata_out,
  // operating mode from the mode-control register
  input wire logic [1:0] operating_mode_field_in,
  // asynchronous supply monitors and LIN bus wake detector
  input wire logic main_regulator_warn_in,
  input wire logic transceiver_regulator_warn_in,
  input wire logic lin_bus_wake_in,
  // interrupt requests, one-cycle pulses
  output logic main_supply_low_irq_out,
  output logic xcvr_supply_low_irq_out,
  output logic lin_wake_irq_out,
  // LIN transceiver control
  output icr_pkg::icr_lin_state_t lin_state_out,
  output logic lin_wake_det_en_out,
  output logic lin_receive_pin_out
);

  // ----------------------------------------------------------------
  // input synchronisation
  // ----------------------------------------------------------------
  icr_pkg::icr_events_t ev_async;
  icr_pkg::icr_events_t ev_sync;

  // pins come from analog comparators, so two flops before any use
  assign ev_async = '{main_warn: main_regulator_warn_in,
                      xcvr_warn: transceiver_regulator_warn_in,
                      lin_wake: lin_bus_wake_in};

  icr_sync #(
    .WIDTH($bits(icr_pkg::icr_events_t))
  ) u_sync (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .async_in(ev_async),
    .sync_out(ev_sync)
  );

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  icr_pkg::icr_ctrl_t ctrl_q;
  icr_pkg::icr_ctrl_t ctrl_d;
  logic sel_hit;
  logic wr_ok;

  // a write lands only when the frame addresses this register
  assign sel_hit = (reg_wdata_in[icr_pkg::ICR_SEL_HI:icr_pkg::ICR_SEL_LO]
                    == icr_pkg::ICR_SELECT);
  assign wr_ok = reg_wr_in && sel_hit && !ctrl_q.write_lock;

  // once locked only a reset reopens it; software cannot unlock itself
  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_ok) begin
      ctrl_d.write_lock = reg_wdata_in[icr_pkg::ICR_LOCK_BIT];
      ctrl_d.main_supply_low_irq_en =
        reg_wdata_in[icr_pkg::ICR_MAIN_EN_BIT];
      ctrl_d.xcvr_supply_low_irq_en =
        reg_wdata_in[icr_pkg::ICR_XCVR_EN_BIT];
      ctrl_d.lin_standby_ctrl = reg_wdata_in[icr_pkg::ICR_STB_BIT];
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ctrl_q.write_lock <= icr_pkg::ICR_LOCK_RST;
      ctrl_q.main_supply_low_irq_en <= icr_pkg::ICR_MAIN_EN_RST;
      ctrl_q.xcvr_supply_low_irq_en <= icr_pkg::ICR_XCVR_EN_RST;
      ctrl_q.lin_standby_ctrl <= icr_pkg::ICR_STB_RST;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;

  // address field is a constant, not storage, so it cannot be written
  always_comb begin
    rdata_d = {icr_pkg::ICR_SELECT, ctrl_q, icr_pkg::ICR_LOW_ZERO};
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      // reset image is built from the same named defaults as the store
      rdata_q <= {icr_pkg::ICR_SELECT,
                  icr_pkg::ICR_LOCK_RST,
                  icr_pkg::ICR_MAIN_EN_RST,
                  icr_pkg::ICR_XCVR_EN_RST,
                  icr_pkg::ICR_STB_RST,
                  icr_pkg::ICR_LOW_ZERO};
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata_out = rdata_q;

  // ----------------------------------------------------------------
  // supply warning requests
  // ----------------------------------------------------------------
  logic main_warn_q;
  logic main_warn_d;
  logic xcvr_warn_q;
  logic xcvr_warn_d;
  logic main_irq_q;
  logic main_irq_d;
  logic xcvr_irq_q;
  logic xcvr_irq_d;

  // a request is raised on the warning's rising edge only while enabled;
  // a warning already standing when the enable is set raises nothing
  always_comb begin
    main_warn_d = ev_sync.main_warn;
    xcvr_warn_d = ev_sync.xcvr_warn;
    main_irq_d = ev_sync.main_warn && !main_warn_q &&
                 ctrl_q.main_supply_low_irq_en;
    xcvr_irq_d = ev_sync.xcvr_warn && !xcvr_warn_q &&
                 ctrl_q.xcvr_supply_low_irq_en;
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      main_warn_q <= 1'h0;
      xcvr_warn_q <= 1'h0;
      main_irq_q <= 1'h0;
      xcvr_irq_q <= 1'h0;
    end else begin
      main_warn_q <= main_warn_d;
      xcvr_warn_q <= xcvr_warn_d;
      main_irq_q <= main_irq_d;
      xcvr_irq_q <= xcvr_irq_d;
    end
  end

  assign main_supply_low_irq_out = main_irq_q;
  assign xcvr_supply_low_irq_out = xcvr_irq_q;

  // ----------------------------------------------------------------
  // LIN transceiver state
  // ----------------------------------------------------------------
  icr_pkg::icr_lin_state_t lin_q;
  icr_pkg::icr_lin_state_t lin_d;

  // mode and standby bit decide the state each cycle
  always_comb begin
    if (ctrl_q.lin_standby_ctrl) begin
      lin_d = icr_pkg::ICR_LIN_LOWPOWER;
    end else begin
      case (operating_mode_field_in)
        icr_pkg::ICR_MODE_NORM_XOFF,
        icr_pkg::ICR_MODE_NORM_XON: begin
          lin_d = icr_pkg::ICR_LIN_ACTIVE;
        end
        icr_pkg::ICR_MODE_STANDBY,
        icr_pkg::ICR_MODE_SLEEP: begin
          lin_d = icr_pkg::ICR_LIN_OFF;
        end
        default: begin
          lin_d = icr_pkg::ICR_LIN_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      lin_q <= icr_pkg::ICR_LIN_OFF;
    end else begin
      lin_q <= lin_d;
    end
  end

  assign lin_state_out = lin_q;
  assign lin_wake_det_en_out = (lin_q == icr_pkg::ICR_LIN_LOWPOWER);

  // ----------------------------------------------------------------
  // LIN wake flag and request
  // ----------------------------------------------------------------
  logic wake_prev_q;
  logic wake_prev_d;
  logic wake_flag_q;
  logic wake_flag_d;
  logic wake_irq_q;
  logic wake_irq_d;
  logic wake_edge;

  // detection runs only in low power; off mode ignores the bus entirely
  assign wake_edge = ev_sync.lin_wake && !wake_prev_q &&
                     (lin_q == icr_pkg::ICR_LIN_LOWPOWER);

  // active mode clears the flag whatever the battery level; wake events
  // cannot occur then, so no set/clear collision arises
  always_comb begin
    wake_prev_d = ev_sync.lin_wake;
    wake_irq_d = wake_edge;
    if (wake_edge) begin
      wake_flag_d = 1'h1;
    end else if (lin_q == icr_pkg::ICR_LIN_ACTIVE) begin
      wake_flag_d = 1'h0;
    end else begin
      wake_flag_d = wake_flag_q;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      wake_prev_q <= 1'h0;
      wake_flag_q <= 1'h0;
      wake_irq_q <= 1'h0;
    end else begin
      wake_prev_q <= wake_prev_d;
      wake_flag_q <= wake_flag_d;
      wake_irq_q <= wake_irq_d;
    end
  end

  // receive pin shows the flag as a low level, idle high
  assign lin_receive_pin_out = !wake_flag_q;
  assign lin_wake_irq_out = wake_irq_q;

endmodule

`default_nettype wire

//--- icr_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module icr_top_test;
  typedef struct packed {
    logic [15:0] wdata;
    logic [1:0] mode;
    logic [15:0] rdata;
    logic [1:0] state;
  } icr_row_t;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic warn_a = 1'b0;
  logic warn_b = 1'b0;
  logic wake = 1'b0;
  logic [1:0] mode = 2'h0;
  logic reg_wr, rx, det, irq_a, irq_b, irq_w;
  logic [15:0] wdata, rdata;
  icr_pkg::icr_lin_state_t state;
  int err_count = 0;
  int checks = 0;
  // four-state counters, so an unknown pulse cannot vanish into zero
  logic [15:0] na, nb, nw;
  // write word, mode, expected readback and lin state
  icr_row_t rows [7] = '{'{16'h4E00, 2'h0, 16'h4E00, 2'h2},
    '{16'h4C00, 2'h3, 16'h4C00, 2'h1}, '{16'h4000, 2'h2, 16'h4000, 2'h1},
    '{16'h4000, 2'h1, 16'h4000, 2'h0}, '{16'h4000, 2'h0, 16'h4000, 2'h0},
    '{16'h2E00, 2'h0, 16'h4000, 2'h0}, '{16'h4FFF, 2'h3, 16'h4E00, 2'h2}};
  icr_host_model icr_host_model_inst (.clk_in(clk_in),
    .reg_wr_out(reg_wr), .reg_wdata_out(wdata));
  icr_top icr_top_inst (.clk_in(clk_in), .reset_in(reset_in),
    .reg_wr_in(reg_wr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
    .operating_mode_field_in(mode), .main_regulator_warn_in(warn_a),
    .transceiver_regulator_warn_in(warn_b), .lin_bus_wake_in(wake),
    .main_supply_low_irq_out(irq_a), .xcvr_supply_low_irq_out(irq_b),
    .lin_wake_irq_out(irq_w), .lin_state_out(state),
    .lin_wake_det_en_out(det), .lin_receive_pin_out(rx));
  // 8 ns clock
  initial forever #4 clk_in = ~clk_in;
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  // pulses are one cycle wide, so each is counted once
  task automatic count8();
    na = 16'h0000;
    nb = 16'h0000;
    nw = 16'h0000;
    repeat (8) begin
      @(posedge clk_in);
      #1;
      na += irq_a;
      nb += irq_b;
      nw += irq_w;
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // main sequence
  initial begin
    tick(2);
    reset_in = 1'b0;
    check(rdata, 16'h4000);
    check({12'h0, rx, det, state}, 16'h0008);
    $display("reset test done");
    foreach (rows[i]) begin
      mode = rows[i].mode;
      icr_host_model_inst.send(rows[i].wdata);
      tick(2);
      check(rdata, rows[i].rdata);
      check(16'(state), 16'(rows[i].state));
    end
    $display("row test done");
    for (int j = 0; j < 2; j++) begin
      icr_host_model_inst.send(j ? 16'h4400 : 16'h4800);
      tick(3);
      warn_a = 1'b1;
      warn_b = 1'b1;
      count8();
      check(16'(na), 16'(1 - j));
      check(16'(nb), 16'(j));
      warn_a = 1'b0;
      warn_b = 1'b0;
      tick(4);
    end
    $display("warning test done");
    mode = 2'h0;
    icr_host_model_inst.send(16'h4E00);
    tick(3);
    wake = 1'b1;
    count8();
    check(16'(nw), 16'h0001);
    check({15'h0, rx}, 16'h0000);
    wake = 1'b0;
    mode = 2'h3;
    icr_host_model_inst.send(16'h4C00);
    tick(3);
    check({15'h0, rx}, 16'h0001);
    wake = 1'b1;
    count8();
    check(16'(nw), 16'h0000);
    wake = 1'b0;
    $display("wake test done");
    icr_host_model_inst.send(16'h5000);
    icr_host_model_inst.send(16'h4E00);
    tick(3);
    check(rdata, 16'h5000);
    $display("lock test done");
    // a reset in mid-run must reopen a locked register
    reset_in = 1'b1;
    tick(2);
    reset_in = 1'b0;
    check(rdata, 16'h4000);
    check({12'h0, rx, det, state}, 16'h0008);
    icr_host_model_inst.send(16'h4200);
    tick(2);
    check(rdata, 16'h4200);
    check(16'(state), 16'h0002);
    $display("mid-run reset test done");
    summarize();
  end
endmodule
`default_nettype wire
